// >>> include/alarm_limits_defs.svh
`ifndef ALARM_LIMITS_DEFS_SVH
`define ALARM_LIMITS_DEFS_SVH
// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define INPUT_LIMIT_BASE 8'h80
`define TEMP_UPPER_LO_ADDR 8'h94
`define TEMP_UPPER_HI_ADDR 8'h95
`define TEMP_LOWER_LO_ADDR 8'h96
`define TEMP_LOWER_HI_ADDR 8'h97
`define INPUT_HYST_BASE 8'ha0
`define TEMP_HYST_ADDR 8'ha5
`define DAC_CLEAR_LOW_ADDR 8'hb0
`define DAC_CLEAR_HIGH_ADDR 8'hb1
`define ALARM_STATUS_ADDR 8'hc0
`define ALARM_MASK_ADDR 8'hc1
// -----------------------------------------------------------------------------
// Reset values and field layout
// -----------------------------------------------------------------------------
`define INPUT_UPPER_LO_RST 8'hff
`define INPUT_UPPER_HI_RST 8'h0f
`define INPUT_LOWER_LO_RST 8'h00
`define INPUT_LOWER_HI_RST 8'h00
`define TEMP_UPPER_LO_RST 8'hff
`define TEMP_UPPER_HI_RST 8'h07
`define TEMP_LOWER_LO_RST 8'h00
`define TEMP_LOWER_HI_RST 8'h08
`define HYST_RST 8'h08
`define DAC_CLEAR_RST 8'h00
`define INPUT_HYST_MASK 8'h7f
`define TEMP_HYST_MASK 8'h1f
`define LIMIT_NIBBLE_MASK 8'h0f
`define NUM_INPUTS 5
`endif

// >>> include/alarm_limits_pkg.sv
package alarm_limits_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [11:0] sample_t;
  typedef enum logic [1:0] {
    ALARM_INSIDE,
    ALARM_RAISED
  } alarm_state_e;
endpackage

// >>> src/window_alarm.sv
`timescale 1ns/10ps
`include "alarm_limits_defs.svh"
module window_alarm #(
  parameter bit SIGNED_CMP = 1'b0
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Synchronous reset.
  input wire logic sample_valid, // New sample present.
  input wire logic [11:0] sample, // Sample value.
  input wire logic [11:0] upper, // Upper limit.
  input wire logic [11:0] lower, // Lower limit.
  input wire logic [6:0] hyst, // Hysteresis in codes.
  output logic alarm // Alarm level.
);
  import alarm_limits_pkg::*;

  logic signed [13:0] s_v, u_v, l_v, h_v;
  logic outside, recovered;
  alarm_state_e state_r;

  // Map both formats onto one signed range so a single compare serves both.
  function automatic logic signed [13:0] widen(input logic [11:0] v);
    if (SIGNED_CMP) begin
      widen = {{2{v[11]}}, v};
    end else begin
      widen = {2'b00, v};
    end
  endfunction

  always_comb begin
    s_v = widen(sample);
    u_v = widen(upper);
    l_v = widen(lower);
    h_v = {7'h00, hyst};
    outside = (u_v <= l_v) || (s_v > u_v) || (s_v < l_v); // see RULE_13
    recovered = (s_v <= u_v - h_v) && (s_v >= l_v + h_v) && (u_v > l_v); // see RULE_15
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ALARM_INSIDE;
    end else if (sample_valid) begin
      case (state_r)
        ALARM_INSIDE: begin
          if (outside) begin
            state_r <= ALARM_RAISED;
          end
        end
        ALARM_RAISED: begin
          if (recovered) begin
            state_r <= ALARM_INSIDE;
          end
        end
        default: state_r <= ALARM_INSIDE;
      endcase
    end
  end

  assign alarm = (state_r == ALARM_RAISED);
endmodule

// >>> src/alarm_threshold_dac_clear_regs.sv
// What this block does
// RULE_01 - Input upper limit: 12 bits, two bytes.
// RULE_02 - Input upper limit resets to full scale.
// RULE_03 - Input lower limit: 12 bits, resets zero.
// RULE_04 - Temperature upper limit 0x94/0x95, resets 0x7ff.
// RULE_05 - Temperature lower limit 0x96/0x97, resets 0x800.
// RULE_06 - High-byte bits 7-4 are inert storage.
// RULE_07 - Input hysteresis 7 bits, resets 0x08.
// RULE_08 - Temperature hysteresis 5 bits at 0xA5.
// RULE_09 - Clear bit one forces DAC clear.
// RULE_10 - Register 0xB0 clears DACs 0 to 7.
// RULE_11 - Register 0xB1 resets to zero.
// RULE_12 - Register 0xB1 clears DACs 8 to 15.
// RULE_13 - Outside window or inverted window sets alarm.
// RULE_14 - Alarms only for unipolar inputs, temperature.
// RULE_15 - Alarm drops only after hysteresis margin.
// RULE_16 - Comparators use both current limit bytes.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`include "alarm_limits_defs.svh"
module alarm_threshold_dac_clear_regs #(
  parameter int NUM_INPUTS = `NUM_INPUTS
) (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output alarm_limits_pkg::reg_byte_t reg_rdata, // Read data, cycle after strobe.
  input wire logic sample_valid, // One-cycle strobe for the sample set.
  input wire logic [NUM_INPUTS*12-1:0] input_sample, // Unipolar samples, straight binary.
  input wire logic [11:0] temp_sample, // Temperature, two's complement.
  output logic [NUM_INPUTS-1:0] input_alarm_flag, // Live alarm per input.
  output logic temp_alarm_flag, // Live temperature alarm.
  output logic [15:0] dac_force_clear, // Per-DAC clear force.
  output logic irq // Level interrupt.
);
  import alarm_limits_pkg::*;

  // Refuse input counts that the register map cannot serve.
  if (NUM_INPUTS < 1 || NUM_INPUTS > 5) begin : g_bad_count
    $error("NUM_INPUTS must be 1 to 5");
  end

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  reg_byte_t in_up_lo_r [NUM_INPUTS];
  reg_byte_t in_up_hi_r [NUM_INPUTS];
  reg_byte_t in_lo_lo_r [NUM_INPUTS];
  reg_byte_t in_lo_hi_r [NUM_INPUTS];
  reg_byte_t in_hyst_r [NUM_INPUTS];
  reg_byte_t t_up_lo_r, t_up_hi_r, t_lo_lo_r, t_lo_hi_r, t_hyst_r;
  reg_byte_t clr_lo_r, clr_hi_r;
  logic [5:0] status_r, mask_r;
  wire logic [5:0] alarm_now;
  logic [5:0] alarm_prev_r;
  reg_byte_t rd_nxt;

  // Input limit block: four bytes per input from 0x80, order up-lo, up-hi, lo-lo, lo-hi.
  function automatic logic lim_hit(input logic [7:0] a, input int n, input int k);
    lim_hit = (a == 8'(`INPUT_LIMIT_BASE + 4 * n + k));
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int n = 0; n < NUM_INPUTS; n++) begin
        in_up_lo_r[n] <= `INPUT_UPPER_LO_RST; // see RULE_02
        in_up_hi_r[n] <= `INPUT_UPPER_HI_RST; // see RULE_02
        in_lo_lo_r[n] <= `INPUT_LOWER_LO_RST; // see RULE_03
        in_lo_hi_r[n] <= `INPUT_LOWER_HI_RST; // see RULE_03
        in_hyst_r[n] <= `HYST_RST; // see RULE_07
      end
    end else if (reg_wr) begin
      for (int n = 0; n < NUM_INPUTS; n++) begin
        if (lim_hit(reg_addr, n, 0)) begin
          in_up_lo_r[n] <= reg_wdata; // see RULE_01
        end
        if (lim_hit(reg_addr, n, 1)) begin
          in_up_hi_r[n] <= reg_wdata; // see RULE_06
        end
        if (lim_hit(reg_addr, n, 2)) begin
          in_lo_lo_r[n] <= reg_wdata; // see RULE_03
        end
        if (lim_hit(reg_addr, n, 3)) begin
          in_lo_hi_r[n] <= reg_wdata;
        end
        if (reg_addr == 8'(`INPUT_HYST_BASE + n)) begin
          in_hyst_r[n] <= reg_wdata; // see RULE_07
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      t_up_lo_r <= `TEMP_UPPER_LO_RST; // see RULE_04
      t_up_hi_r <= `TEMP_UPPER_HI_RST;
      t_lo_lo_r <= `TEMP_LOWER_LO_RST; // see RULE_05
      t_lo_hi_r <= `TEMP_LOWER_HI_RST;
      t_hyst_r <= `HYST_RST; // see RULE_08
    end else if (reg_wr) begin
      case (reg_addr)
        `TEMP_UPPER_LO_ADDR: t_up_lo_r <= reg_wdata; // see RULE_04
        `TEMP_UPPER_HI_ADDR: t_up_hi_r <= reg_wdata;
        `TEMP_LOWER_LO_ADDR: t_lo_lo_r <= reg_wdata; // see RULE_05
        `TEMP_LOWER_HI_ADDR: t_lo_hi_r <= reg_wdata;
        `TEMP_HYST_ADDR: t_hyst_r <= reg_wdata; // see RULE_08
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clr_lo_r <= `DAC_CLEAR_RST; // see RULE_10
      clr_hi_r <= `DAC_CLEAR_RST; // see RULE_11
    end else if (reg_wr) begin
      if (reg_addr == `DAC_CLEAR_LOW_ADDR) begin
        clr_lo_r <= reg_wdata; // see RULE_10
      end
      if (reg_addr == `DAC_CLEAR_HIGH_ADDR) begin
        clr_hi_r <= reg_wdata; // see RULE_12
      end
    end
  end

  // ---------------------------------------------------------------------------
  // DAC clear outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dac_force_clear <= 16'h0000;
    end else begin
      dac_force_clear <= {clr_hi_r, clr_lo_r}; // see RULE_09
    end
  end

  // ---------------------------------------------------------------------------
  // Window comparators
  // ---------------------------------------------------------------------------
  // Only the unipolar inputs and temperature get comparators.
  for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_in // see RULE_14
    window_alarm #(
      .SIGNED_CMP(1'b0)
    ) u_cmp (
      .clk(clk),
      .sys_rst(sys_rst),
      .sample_valid(sample_valid),
      .sample(input_sample[g*12 +: 12]),
      .upper({in_up_hi_r[g][3:0], in_up_lo_r[g]}), // see RULE_16
      .lower({in_lo_hi_r[g][3:0], in_lo_lo_r[g]}), // see RULE_16
      .hyst(in_hyst_r[g][6:0]),
      .alarm(alarm_now[g])
    );
  end
  if (NUM_INPUTS < 5) begin : g_pad
    assign alarm_now[4:NUM_INPUTS] = '0;
  end

  window_alarm #(
    .SIGNED_CMP(1'b1)
  ) u_temp (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_valid(sample_valid),
    .sample(temp_sample),
    .upper({t_up_hi_r[3:0], t_up_lo_r}), // see RULE_16
    .lower({t_lo_hi_r[3:0], t_lo_lo_r}),
    .hyst({2'b00, t_hyst_r[4:0]}),
    .alarm(alarm_now[5])
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      input_alarm_flag <= '0;
      temp_alarm_flag <= 1'b0;
      alarm_prev_r <= '0;
    end else begin
      input_alarm_flag <= alarm_now[NUM_INPUTS-1:0];
      temp_alarm_flag <= alarm_now[5];
      alarm_prev_r <= alarm_now;
    end
  end

  // ---------------------------------------------------------------------------
  // Sticky status, mask and interrupt
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_r <= '0;
    end else begin
      // A rising alarm in the clearing cycle wins over the clear.
      status_r <= (status_r & ~((reg_wr && reg_addr == `ALARM_STATUS_ADDR) ? reg_wdata[5:0] : 6'h00))
                  | (alarm_now & ~alarm_prev_r); // see RULE_13
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_r <= '0;
    end else if (reg_wr && reg_addr == `ALARM_MASK_ADDR) begin
      mask_r <= reg_wdata[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_nxt = 8'h00;
    for (int n = 0; n < NUM_INPUTS; n++) begin
      if (lim_hit(reg_addr, n, 0)) rd_nxt = in_up_lo_r[n];
      if (lim_hit(reg_addr, n, 1)) rd_nxt = in_up_hi_r[n]; // see RULE_06
      if (lim_hit(reg_addr, n, 2)) rd_nxt = in_lo_lo_r[n];
      if (lim_hit(reg_addr, n, 3)) rd_nxt = in_lo_hi_r[n];
      if (reg_addr == 8'(`INPUT_HYST_BASE + n)) rd_nxt = in_hyst_r[n];
    end
    case (reg_addr)
      `TEMP_UPPER_LO_ADDR: rd_nxt = t_up_lo_r;
      `TEMP_UPPER_HI_ADDR: rd_nxt = t_up_hi_r;
      `TEMP_LOWER_LO_ADDR: rd_nxt = t_lo_lo_r;
      `TEMP_LOWER_HI_ADDR: rd_nxt = t_lo_hi_r;
      `TEMP_HYST_ADDR: rd_nxt = t_hyst_r;
      `DAC_CLEAR_LOW_ADDR: rd_nxt = clr_lo_r;
      `DAC_CLEAR_HIGH_ADDR: rd_nxt = clr_hi_r;
      `ALARM_STATUS_ADDR: rd_nxt = {2'b00, status_r};
      `ALARM_MASK_ADDR: rd_nxt = {2'b00, mask_r};
      default: ;
    endcase
  end

  // Read data stand for one cycle after the strobe and are zero otherwise.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_clr_write;
    reg_wr && reg_addr == `DAC_CLEAR_LOW_ADDR;
  endsequence

  a_clear_low_out: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_09
    s_clr_write |-> ##2 dac_force_clear[7:0] == $past(reg_wdata, 2))
    else $error("Low DAC clear output mismatch");

  a_clear_high_out: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_12
    reg_wr && reg_addr == `DAC_CLEAR_HIGH_ADDR |-> ##2 dac_force_clear[15:8] == $past(reg_wdata, 2))
    else $error("High DAC clear output mismatch");

  a_reset_values: assert property (@(posedge clk) // see RULE_02
    !sys_rst && $past(sys_rst) |-> in_up_lo_r[0] == 8'hff && in_up_hi_r[0] == 8'h0f && in_lo_hi_r[0] == 8'h00)
    else $error("Input limit reset values wrong");

  a_temp_reset: assert property (@(posedge clk) // see RULE_04
    !sys_rst && $past(sys_rst) |-> t_up_hi_r == 8'h07 && t_lo_hi_r == 8'h08 && t_hyst_r == 8'h08)
    else $error("Temperature limit reset values wrong");

  a_clear_reset: assert property (@(posedge clk) // see RULE_11
    !sys_rst && $past(sys_rst) |-> clr_lo_r == 8'h00 && clr_hi_r == 8'h00)
    else $error("DAC clear reset wrong");

  a_readback_hyst: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_08
    reg_rd && reg_addr == `TEMP_HYST_ADDR |=> reg_rdata == $past(t_hyst_r))
    else $error("Temperature hysteresis readback wrong");

  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_10
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data not zero outside read");

  a_inverted_window: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_13
    sample_valid && {in_up_hi_r[0][3:0], in_up_lo_r[0]} <= {in_lo_hi_r[0][3:0], in_lo_lo_r[0]}
    |-> ##2 input_alarm_flag[0])
    else $error("Inverted window did not alarm");

  a_irq_masked: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_15
    (status_r & mask_r) == 6'h00 |=> !irq)
    else $error("Interrupt raised while masked");

  sequence s_alarm_rise;
    (alarm_now & ~alarm_prev_r) != 6'h00;
  endsequence

  sequence s_status_clear;
    reg_wr && reg_addr == `ALARM_STATUS_ADDR;
  endsequence

  // Status bits must set on a rising alarm even when software clears them in the same cycle.
  a_status_sets: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_13
    s_alarm_rise |=> (status_r & $past(alarm_now & ~alarm_prev_r)) == $past(alarm_now & ~alarm_prev_r))
    else $error("Rising alarm did not set its status bit");

  a_status_w1c: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_13
    s_status_clear |=> (status_r & $past(reg_wdata[5:0] & ~(alarm_now & ~alarm_prev_r))) == 6'h00)
    else $error("Status bit survived a write-one clear");

  a_irq_unmasked: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_13
    (status_r & mask_r) != 6'h00 |=> irq)
    else $error("Unmasked status did not raise the interrupt");

  a_dac_out_follows: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_09
    !$past(sys_rst) |-> dac_force_clear == $past({clr_hi_r, clr_lo_r}))
    else $error("DAC clear outputs do not follow the registers");

  a_flags_follow: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_14
    !$past(sys_rst) |->
    input_alarm_flag == $past(alarm_now[NUM_INPUTS-1:0]) && temp_alarm_flag == $past(alarm_now[5]))
    else $error("Alarm flags do not follow the comparators");

  a_last_input_reset: assert property (@(posedge clk) // see RULE_02
    !sys_rst && $past(sys_rst) |-> in_up_lo_r[NUM_INPUTS-1] == 8'hff && in_up_hi_r[NUM_INPUTS-1] == 8'h0f)
    else $error("Last input upper limit reset wrong");

  a_hyst_reset: assert property (@(posedge clk) // see RULE_07
    !sys_rst && $past(sys_rst) |-> in_hyst_r[0] == 8'h08 && in_lo_lo_r[0] == 8'h00)
    else $error("Input hysteresis or lower limit reset wrong");

  a_temp_low_reset: assert property (@(posedge clk) // see RULE_05
    !sys_rst && $past(sys_rst) |-> t_up_lo_r == 8'hff && t_lo_lo_r == 8'h00)
    else $error("Temperature limit low bytes reset wrong");

  a_readback_clear_high: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_12
    reg_rd && reg_addr == `DAC_CLEAR_HIGH_ADDR |=> reg_rdata == $past(clr_hi_r))
    else $error("High DAC clear readback wrong");

  a_readback_reserved: assert property (@(posedge clk) disable iff (sys_rst) // see RULE_06
    reg_rd && reg_addr == `TEMP_UPPER_HI_ADDR |=> reg_rdata == $past(t_up_hi_r))
    else $error("Temperature upper high byte readback wrong");
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import alarm_limits_pkg::*;
  logic clk;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  reg_byte_t reg_rdata;
  logic sample_valid;
  logic [59:0] input_sample;
  logic [11:0] temp_sample;
  logic [4:0] input_alarm_flag;
  logic temp_alarm_flag;
  logic [15:0] dac_force_clear;
  logic irq;
  int n_fail;
  int compares;
  int cycles;
  alarm_threshold_dac_clear_regs #(.NUM_INPUTS(5)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .input_sample(input_sample), .temp_sample(temp_sample), .input_alarm_flag(input_alarm_flag),
    .temp_alarm_flag(temp_alarm_flag), .dac_force_clear(dac_force_clear), .irq(irq)
  );
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  // Drives one sample set; inputs 2 to 4 sit at quarter scale (0x400), then waits for the flags.
  task automatic samp(input logic [11:0] i0, input logic [11:0] i1, input logic [11:0] t);
    @(posedge clk);
    sample_valid <= 1'b1;
    input_sample <= {36'h400400400, i1, i0};
    temp_sample <= t;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic wait_chk_irq(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, irq}, {15'h0, e});
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    for (int n = 0; n < 5; n++) begin
      rd_chk(8'h80 + 8'(4 * n), 8'hff);
      rd_chk(8'h81 + 8'(4 * n), 8'h0f);
      rd_chk(8'h82 + 8'(4 * n), 8'h00);
      rd_chk(8'h83 + 8'(4 * n), 8'h00);
      rd_chk(8'ha0 + 8'(n), 8'h08);
    end
    rd_chk(8'h94, 8'hff);
    rd_chk(8'h95, 8'h07);
    rd_chk(8'h96, 8'h00);
    rd_chk(8'h97, 8'h08);
    rd_chk(8'ha5, 8'h08);
    rd_chk(8'hb0, 8'h00);
    rd_chk(8'hb1, 8'h00);
    rd_chk(8'hc0, 8'h00);
    rd_chk(8'hc1, 8'h00);
    rd_chk(8'h70, 8'h00);
    @(posedge clk);
    #1;
    chk({8'h00, reg_rdata}, 16'h0000);
    chk(dac_force_clear, 16'h0000);
    $display("test reset values done");
  endtask
  task automatic t_dac();
    wr(8'hb0, 8'ha5);
    wr(8'hb1, 8'h3c);
    repeat (2) @(posedge clk);
    #1;
    chk(dac_force_clear, 16'h3ca5);
    rd_chk(8'hb0, 8'ha5);
    rd_chk(8'hb1, 8'h3c);
    wr(8'hb0, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk(dac_force_clear, 16'h3c00);
    wr(8'h70, 8'hff);
    rd_chk(8'h70, 8'h00);
    wr(8'hb0, 8'hff);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(dac_force_clear, 16'h0000);
    rd_chk(8'hb0, 8'h00);
    $display("test dac clear done");
  endtask
  task automatic t_input();
    wr(8'h80, 8'h00);
    wr(8'h81, 8'hf8); // Upper nibble must be ignored by the comparator.
    wr(8'h82, 8'h00);
    wr(8'h83, 8'h01);
    wr(8'ha0, 8'h10);
    samp(12'h400, 12'h400, 12'h000);
    chk({11'h0, input_alarm_flag}, 16'h0000);
    samp(12'h801, 12'h400, 12'h000);
    chk({11'h0, input_alarm_flag}, 16'h0001);
    samp(12'h7f8, 12'h400, 12'h000);
    chk({11'h0, input_alarm_flag}, 16'h0001);
    samp(12'h7f0, 12'h400, 12'h000);
    chk({11'h0, input_alarm_flag}, 16'h0000);
    samp(12'h0ff, 12'h400, 12'h000);
    chk({11'h0, input_alarm_flag}, 16'h0001);
    samp(12'h400, 12'h400, 12'h000);
    wr(8'h84, 8'h00);
    wr(8'h85, 8'h01);
    wr(8'h86, 8'h00);
    wr(8'h87, 8'h02);
    samp(12'h400, 12'h150, 12'h000);
    chk({11'h0, input_alarm_flag}, 16'h0002);
    chk({15'h0, temp_alarm_flag}, 16'h0000);
    rd_chk(8'hc0, 8'h03);
    chk({15'h0, irq}, 16'h0000);
    wr(8'hc1, 8'h02);
    wait_chk_irq(1'b1);
    wr(8'hc0, 8'h02);
    wait_chk_irq(1'b0);
    rd_chk(8'hc0, 8'h01);
    wr(8'hc1, 8'h01);
    wait_chk_irq(1'b1);
    wr(8'hc0, 8'h01);
    wait_chk_irq(1'b0);
    $display("test input alarms done");
  endtask
  task automatic t_temp();
    wr(8'hc0, 8'hff);
    wr(8'h95, 8'ha7);
    rd_chk(8'h95, 8'ha7);
    samp(12'h400, 12'h400, 12'h7f0);
    chk({15'h0, temp_alarm_flag}, 16'h0000);
    wr(8'h94, 8'h50);
    wr(8'h95, 8'h00);
    wr(8'h96, 8'hec);
    wr(8'h97, 8'h0f);
    wr(8'ha5, 8'h05);
    samp(12'h400, 12'h400, 12'hfe0);
    chk({15'h0, temp_alarm_flag}, 16'h0001);
    samp(12'h400, 12'h400, 12'hff0);
    chk({15'h0, temp_alarm_flag}, 16'h0001);
    samp(12'h400, 12'h400, 12'hff1);
    chk({15'h0, temp_alarm_flag}, 16'h0000);
    samp(12'h400, 12'h400, 12'h060);
    chk({15'h0, temp_alarm_flag}, 16'h0001);
    rd_chk(8'hc0, 8'h20);
    $display("test temperature alarm done");
  endtask
  task automatic t_storage();
    for (int n = 0; n < 20; n++) begin
      wr(8'h80 + 8'(n), 8'hc0 + 8'(n));
    end
    for (int n = 0; n < 5; n++) begin
      wr(8'ha0 + 8'(n), 8'h40 + 8'(n));
    end
    wr(8'ha5, 8'h1f);
    for (int n = 0; n < 20; n++) begin
      rd_chk(8'h80 + 8'(n), 8'hc0 + 8'(n));
    end
    for (int n = 0; n < 5; n++) begin
      rd_chk(8'ha0 + 8'(n), 8'h40 + 8'(n));
    end
    rd_chk(8'ha5, 8'h1f);
    samp(12'h400, 12'h400, 12'h000);
    chk({11'h0, input_alarm_flag}, 16'h001f);
    chk({15'h0, temp_alarm_flag}, 16'h0001);
    chk({15'h0, irq}, 16'h0001);
    $display("test register storage done");
  endtask
  // ---------------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("timeout at %0t", $time);
      final_report();
    end
  end
  initial begin
    n_fail = 0;
    compares = 0;
    cycles = 0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sample_valid = 1'b0;
    input_sample = 60'h0;
    temp_sample = 12'h000;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_dac();
    t_input();
    t_temp();
    t_storage();
    final_report();
  end
endmodule
